// [common/daio_pkg.sv]
package daio_pkg;

  localparam int DAC_WIDTH = 16;
  localparam int DIO_WIDTH = 8;
  localparam int NUM_AO    = 2;
  localparam int ADDR_W    = 5;
  localparam int TRIG_W    = 4;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CODE_A = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CODE_B = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_GAIN   = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_DIN    = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_DOUT   = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h14;

  // status field positions
  localparam int ST_ARMED  = 0;
  localparam int ST_GAIN_E = 1;
  localparam int ST_DRIVEN = 2;
  localparam int ST_BUSY   = 3;

  // reset values
  localparam logic [DAC_WIDTH-1:0] CODE_RST = 16'h8000;
  localparam logic [7:0]           GAIN_ONE = 8'h01;
  localparam logic [DIO_WIDTH-1:0] DOUT_RST = 8'h00;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } daio_bus_t;

endpackage : daio_pkg

// [common/daio_chan_if.sv]
`timescale 1ns/100ps
interface daio_chan_if import daio_pkg::*; ();
  logic                 wr_lo;
  logic                 wr_hi;
  logic [DAC_WIDTH-1:0] wdata;
  logic [DAC_WIDTH-1:0] code;
  logic                 busy;

  modport ctl  (output wr_lo, output wr_hi, output wdata,
                input code, input busy);
  modport chan (input wr_lo, input wr_hi, input wdata,
                output code, output busy);
endinterface : daio_chan_if

// [rtl/daio_dac_chan.sv]
`timescale 1ns/100ps
module daio_dac_chan import daio_pkg::*; (
  input wire logic  clock,
  input wire logic  sys_rst,
  input wire logic  por_rst,
  daio_chan_if.chan ch
);
  logic [DAC_WIDTH-1:0] stage1_q;
  logic [DAC_WIDTH-1:0] stage2_q;
  logic [1:0]           loaded_q;
  logic [1:0]           loaded_d;
  logic                 xfer_q;
  logic                 full;

  // byte lanes collected until the whole word is present
  assign loaded_d = loaded_q | {ch.wr_hi, ch.wr_lo};
  assign full     = &loaded_d;

  // code stages only cleared by power-up
  always_ff @(posedge clock or posedge por_rst) begin
    if (por_rst) begin
      stage1_q <= CODE_RST; // midscale is 0 V
      stage2_q <= CODE_RST;
    end else begin
      if (ch.wr_lo) stage1_q[7:0]  <= ch.wdata[7:0];
      if (ch.wr_hi) stage1_q[15:8] <= ch.wdata[15:8];
      if (xfer_q)   stage2_q <= stage1_q;
    end
  end

  // load tracking and transfer strobe
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      loaded_q <= 2'h0;
      xfer_q   <= 1'b0;
    end else begin
      loaded_q <= full ? 2'h0 : loaded_d;
      xfer_q   <= full;
    end
  end

  assign ch.code = stage2_q;
  assign ch.busy = xfer_q | (|loaded_q);

  a_xfer_after_load: assert property (
    @(posedge clock) disable iff (sys_rst || por_rst)
    full |=> xfer_q ##1 !xfer_q || full)
    else $error("transfer not one cycle after full load");

  a_stage2_hold: assert property (
    @(posedge clock) disable iff (por_rst)
    !xfer_q |=> $stable(stage2_q))
    else $error("output stage changed without transfer");

  a_stage2_copy: assert property (
    @(posedge clock) disable iff (sys_rst || por_rst)
    xfer_q |=> stage2_q == $past(stage1_q))
    else $error("output stage did not take first stage");

endmodule : daio_dac_chan

// [rtl/daio_top.sv]
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module daio_top import daio_pkg::*; #(
  parameter int DAC_W = DAC_WIDTH,
  parameter int DIO_W = DIO_WIDTH
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              por_rst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic [DIO_W-1:0]  din_pin,
  output logic      [DIO_W-1:0]  dout_pin,
  output logic                   dout_drive,
  output logic      [DAC_W-1:0]  analog_out_channel_a,
  output logic      [DAC_W-1:0]  analog_out_channel_b,
  output logic      [TRIG_W-1:0] ad_start,
  output logic      [TRIG_W-1:0] ad_stop
);

  // widths the logic is built for
  if (DAC_W != DAC_WIDTH) begin : g_bad_dac
    $error("analog code width must be 16");
  end
  if (DIO_W != 2 * TRIG_W) begin : g_bad_dio
    $error("digital port width must be 8");
  end

  daio_bus_t st_q;
  daio_bus_t st_d;
  logic [31:0]       readdata_q;
  logic [31:0]       rd_mux;
  logic [DIO_W-1:0]  din_m_q;
  logic [DIO_W-1:0]  din_s_q;
  logic [DIO_W-1:0]  din_p_q;
  logic [DIO_W-1:0]  fall;
  logic [DIO_W-1:0]  dout_q;
  logic              driven_q;
  logic              armed_q;
  logic              gain_err_q;
  logic              gain_err_d;
  logic [TRIG_W-1:0] start_q;
  logic [TRIG_W-1:0] stop_q;
  logic [NUM_AO-1:0] ch_wr;
  logic [NUM_AO-1:0] ch_busy;
  logic [DAC_W-1:0]  ch_code [NUM_AO];

  // bus request decode
  wire       req      = avs_read | avs_write;
  wire       idle     = (st_q == BUS_IDLE);
  wire       accept   = req & (st_q == BUS_ACK);
  wire       wr_acc   = avs_write & accept;
  wire [2:0] word     = avs_address[ADDR_W-1:2];
  wire       sel_a    = (word == OFS_CODE_A[ADDR_W-1:2]);
  wire       sel_b    = (word == OFS_CODE_B[ADDR_W-1:2]);
  wire       sel_gain = (word == OFS_GAIN[ADDR_W-1:2]);
  wire       sel_din  = (word == OFS_DIN[ADDR_W-1:2]);
  wire       sel_dout = (word == OFS_DOUT[ADDR_W-1:2]);
  wire       sel_st   = (word == OFS_STATUS[ADDR_W-1:2]);
  wire       sel_none = ~(sel_a | sel_b | sel_gain | sel_din | sel_dout |
                          sel_st);

  // every request is answered after one wait cycle
  assign st_d            = (req && idle) ? BUS_ACK : BUS_IDLE;
  assign avs_waitrequest = req & ~(st_q == BUS_ACK);
  assign avs_readdata    = readdata_q;

  // bus handshake state
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) st_q <= BUS_IDLE;
    else         st_q <= st_d;
  end

  // one analog channel per access, selected by address
  wire [NUM_AO-1:0] ch_sel = {sel_b, sel_a};

  genvar g;
  for (g = 0; g < NUM_AO; g++) begin : g_ao
    daio_chan_if ch_if ();
    assign ch_if.wr_lo = wr_acc & ch_sel[g] & avs_byteenable[0];
    assign ch_if.wr_hi = wr_acc & ch_sel[g] & avs_byteenable[1];
    assign ch_if.wdata = avs_writedata[DAC_W-1:0];
    assign ch_wr[g]    = ch_if.wr_lo | ch_if.wr_hi;
    assign ch_busy[g]  = ch_if.busy;
    assign ch_code[g]  = ch_if.code;

    daio_dac_chan u_chan (
      .clock   (clock),
      .sys_rst (sys_rst),
      .por_rst (por_rst),
      .ch      (ch_if.chan)
    );
  end

  assign analog_out_channel_a = ch_code[0];
  assign analog_out_channel_b = ch_code[1];

  // gain writes other than one are refused
  wire gain_wr  = wr_acc & sel_gain;
  wire gain_bad = (avs_byteenable[0] && avs_writedata[7:0] != GAIN_ONE) ||
                  (avs_byteenable[1] && avs_writedata[15:8] != GAIN_ONE);
  wire st_clr   = wr_acc & sel_st & avs_byteenable[0] &
                  avs_writedata[ST_GAIN_E];
  // set wins over a clear in the same cycle
  assign gain_err_d = (gain_wr & gain_bad) | (gain_err_q & ~st_clr);

  // input synchroniser and edge history
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      din_m_q <= '0;
      din_s_q <= '0;
      din_p_q <= '0;
    end else begin
      din_m_q <= din_pin;
      din_s_q <= din_m_q;
      din_p_q <= din_s_q;
    end
  end

  // falls count only once armed
  assign fall = din_p_q & ~din_s_q & {DIO_W{armed_q}};

  // arming and trigger pulses
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      armed_q <= 1'b0;
      start_q <= '0;
      stop_q  <= '0;
    end else begin
      armed_q <= armed_q | (&din_s_q);
      start_q <= fall[TRIG_W-1:0];
      stop_q  <= fall[DIO_W-1:TRIG_W];
    end
  end

  assign ad_start = start_q;
  assign ad_stop  = stop_q;

  // output port stays undriven until written
  wire dout_wr = wr_acc & sel_dout & avs_byteenable[0];

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dout_q     <= DOUT_RST;
      driven_q   <= 1'b0;
      gain_err_q <= 1'b0;
    end else begin
      if (dout_wr) dout_q <= avs_writedata[DIO_W-1:0];
      driven_q   <= driven_q | dout_wr;
      gain_err_q <= gain_err_d;
    end
  end

  assign dout_pin   = dout_q;
  assign dout_drive = driven_q;

  // status word
  wire [31:0] status = {{(32-ST_BUSY-NUM_AO){1'b0}}, ch_busy,
                        driven_q, gain_err_q, armed_q};

  // read selection, gain ignored on port reads, unmapped read zero
  assign rd_mux =
    sel_a    ? {16'h0000, ch_code[0]} :
    sel_b    ? {16'h0000, ch_code[1]} :
    sel_gain ? {16'h0000, GAIN_ONE, GAIN_ONE} :
    sel_din  ? {24'h000000, din_s_q} :
    sel_dout ? {24'h000000, dout_q} :
    sel_st   ? status : 32'h00000000;

  // read data captured in the wait cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst)                readdata_q <= 32'h00000000;
    else if (avs_read && idle)  readdata_q <= rd_mux;
  end

  sequence s_first_cycle;
    req && idle;
  endsequence

  sequence s_falls_low;
    armed_q && (|(din_p_q[TRIG_W-1:0] & ~din_s_q[TRIG_W-1:0]));
  endsequence

  a_wait_first: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_first_cycle |-> avs_waitrequest)
    else $error("request answered without wait cycle");

  a_accept_next: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_first_cycle ##1 req |-> !avs_waitrequest)
    else $error("request not answered in second cycle");

  a_one_channel: assert property (
    @(posedge clock) disable iff (sys_rst)
    $onehot0(ch_wr))
    else $error("two analog channels written at once");

  a_dout_first: assert property (
    @(posedge clock) disable iff (sys_rst)
    $rose(dout_drive) |-> $past(wr_acc && sel_dout))
    else $error("output port driven without a write");

  a_dout_value: assert property (
    @(posedge clock) disable iff (sys_rst)
    dout_wr |=> dout_pin == $past(avs_writedata[DIO_W-1:0]))
    else $error("output port missed written value");

  a_start_edge: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_falls_low |=> ad_start ==
      $past(din_p_q[TRIG_W-1:0] & ~din_s_q[TRIG_W-1:0]))
    else $error("start pulse does not follow input fall");

  a_no_arm: assert property (
    @(posedge clock) disable iff (sys_rst)
    !armed_q |=> ad_start == '0 && ad_stop == '0)
    else $error("trigger pulse before inputs armed");

  a_gain_reject: assert property (
    @(posedge clock) disable iff (sys_rst)
    gain_wr && gain_bad |=> gain_err_q)
    else $error("bad gain write not flagged");

  a_code_keep: assert property (
    @(posedge clock) disable iff (por_rst)
    sys_rst |=> $stable(analog_out_channel_a) &&
                $stable(analog_out_channel_b))
    else $error("module reset disturbed analog codes");

  // read answer: the word captured in the wait cycle
  sequence s_read_cycle;
    (avs_read && idle) ##1 avs_read;
  endsequence

  sequence s_falls_high;
    armed_q && (|(din_p_q[DIO_W-1:TRIG_W] & ~din_s_q[DIO_W-1:TRIG_W]));
  endsequence

  // bus answer checks
  a_read_stands: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_read_cycle |-> avs_readdata == $past(rd_mux))
    else $error("read data not the word selected in wait cycle");

  a_unmapped_read: assert property (
    @(posedge clock) disable iff (sys_rst)
    (avs_read && idle && sel_none) ##1 avs_read |->
      avs_readdata == 32'h00000000)
    else $error("unmapped read did not return zero");

  a_quiet_idle: assert property (
    @(posedge clock) disable iff (sys_rst)
    !req |-> !avs_waitrequest)
    else $error("wait asserted with no request");

  // trigger checks
  a_stop_edge: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_falls_high |=> ad_stop ==
      $past(din_p_q[DIO_W-1:TRIG_W] & ~din_s_q[DIO_W-1:TRIG_W]))
    else $error("stop pulse does not follow input fall");

  a_pulse_once: assert property (
    @(posedge clock) disable iff (sys_rst)
    (|{ad_stop, ad_start}) |=>
      ({ad_stop, ad_start} & $past({ad_stop, ad_start})) == '0)
    else $error("trigger pulse longer than one cycle");

  a_armed_hold: assert property (
    @(posedge clock) disable iff (sys_rst)
    armed_q |=> armed_q)
    else $error("arming lost without module reset");

  a_arm_all_high: assert property (
    @(posedge clock) disable iff (sys_rst)
    $rose(armed_q) |-> $past(&din_s_q))
    else $error("armed before every input seen high");

  // gain flag checks
  a_gain_clear: assert property (
    @(posedge clock) disable iff (sys_rst)
    st_clr && !(gain_wr && gain_bad) |=> !gain_err_q)
    else $error("gain error not cleared by write of one");

  a_gain_hold: assert property (
    @(posedge clock) disable iff (sys_rst)
    !gain_wr && !st_clr |=> gain_err_q == $past(gain_err_q))
    else $error("gain error changed without a write");

  // output port and channel checks
  a_dout_hold: assert property (
    @(posedge clock) disable iff (sys_rst)
    !dout_wr |=> $stable(dout_pin))
    else $error("output port changed without a write");

  a_drive_hold: assert property (
    @(posedge clock) disable iff (sys_rst)
    dout_drive |=> dout_drive)
    else $error("output port released without module reset");

  a_busy_on_write: assert property (
    @(posedge clock) disable iff (sys_rst)
    (|ch_wr) |=> (ch_busy & $past(ch_wr)) != '0)
    else $error("written channel not shown busy");

endmodule : daio_top

// [bench/daio_field.sv]
`timescale 1ns/100ps
module daio_field import daio_pkg::*; (
  input  wire logic [DIO_WIDTH-1:0] pull_low,
  input  wire logic [DIO_WIDTH-1:0] dout_pin,
  input  wire logic                 dout_drive,
  output logic      [DIO_WIDTH-1:0] din_pin,
  output logic      [DIO_WIDTH-1:0] load_seen
);
  // pull-ups hold every released input line high
  assign din_pin   = ~pull_low;
  // load follows the port only while new data is driven;
  // undriven lines show the inverse so stale data cannot pass
  assign load_seen = dout_drive ? dout_pin : ~dout_pin;
endmodule : daio_field

// [bench/testbench.sv]
`timescale 1ns/100ps
module testbench import daio_pkg::*;;
  logic        clock, sys_rst, por_rst, avs_read, avs_write;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdat;
  logic [3:0]  avs_byteenable;
  logic        avs_waitrequest, dout_drive;
  logic [7:0]  din_pin, dout_pin, pull_low, load_seen;
  logic [15:0] ao_a, ao_b;
  logic [3:0]  ad_start, ad_stop;
  int          num_errors, comparisons;

  // field side: pulled-up inputs and output load
  daio_field u_daio_field (.pull_low(pull_low), .dout_pin(dout_pin),
    .dout_drive(dout_drive), .din_pin(din_pin), .load_seen(load_seen));

  daio_top u_daio_top (.clock(clock), .sys_rst(sys_rst), .por_rst(por_rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .din_pin(din_pin),
    .dout_pin(dout_pin), .dout_drive(dout_drive),
    .analog_out_channel_a(ao_a), .analog_out_channel_b(ao_b),
    .ad_start(ad_start), .ad_stop(ad_stop));

  // free-running clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic finish_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // one bus access, held until waitrequest is seen low at a rising edge
  task automatic bus(logic wr, logic [4:0] a, logic [31:0] d,
                     logic [3:0] be);
    int n;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    rdat = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n == 50) begin
      num_errors++;
      finish_test();
    end else begin
      @(posedge clock);
    end
  endtask : bus

  // waits for one trigger pulse and compares all eight bits
  task automatic pulse_chk(logic [7:0] exp);
    int n;
    for (n = 0; n < 12; n++) begin
      @(negedge clock);
      if ({ad_stop, ad_start} !== 8'h00) break;
    end
    chk("trigger", {ad_stop, ad_start}, exp);
    @(posedge clock);
  endtask : pulse_chk

  // falls before arming are dropped, then each line triggers
  task automatic t_trig;
    pull_low <= 8'h03;
    pulse_chk(8'h00);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF);
    chk("armed early", rdat[ST_ARMED], 1'b0);
    pull_low <= 8'h00;
    repeat (6) @(posedge clock);
    for (int i = 0; i < 8; i++) begin // no port reads here
      pull_low <= 8'h01 << i;
      pulse_chk(8'h01 << i);
      pull_low <= 8'h00;
      repeat (6) @(posedge clock);
    end
  endtask : t_trig

  // full and lane-wise code loads, one channel each
  task automatic t_code;
    bus(1'b1, OFS_CODE_A, 32'h784D, 4'h3);
    @(posedge clock);
    chk("code a", ao_a, 16'h784D);
    chk("code b", ao_b, CODE_RST);
    bus(1'b0, OFS_CODE_A, 32'h0, 4'hF);
    chk("code a read", rdat, 32'h784D);
    bus(1'b1, OFS_CODE_B, 32'hFFFF, 4'h1);
    @(posedge clock);
    chk("code b half", ao_b, CODE_RST);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF);
    chk("b pending", rdat[ST_BUSY+1], 1'b1);
    bus(1'b1, OFS_CODE_B, 32'h1234, 4'h2);
    @(posedge clock);
    chk("code b full", ao_b, 16'h12FF);
    chk("code a kept", ao_a, 16'h784D);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF);
    chk("b settled", rdat[ST_BUSY+1], 1'b0);
  endtask : t_code

  // output port write, input port read, then module reset
  task automatic t_dio;
    bus(1'b1, OFS_DOUT, 32'h1A5, 4'h1);
    chk("dout", load_seen, 8'hA5);
    chk("drive", dout_drive, 1'b1);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF);
    chk("driven bit", rdat[ST_DRIVEN], 1'b1);
    bus(1'b0, OFS_DIN, 32'h0, 4'hF);
    chk("din", rdat, 32'hFF);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    chk("reset a", ao_a, 16'h784D);
    chk("reset b", ao_b, 16'h12FF);
    chk("reset drive", dout_drive, 1'b0);
    chk("reset dout", dout_pin, DOUT_RST);
    @(posedge clock);
  endtask : t_dio

  // gain other than one flagged, cleared, unmapped place reads 0
  task automatic t_gain;
    bus(1'b1, OFS_GAIN, 32'h0101, 4'h3);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF);
    chk("gain ok", rdat[ST_GAIN_E], 1'b0);
    bus(1'b1, OFS_GAIN, 32'h0202, 4'h3);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF);
    chk("gain bad", rdat[ST_GAIN_E], 1'b1);
    bus(1'b0, OFS_GAIN, 32'h0, 4'hF);
    chk("gain read", rdat, 32'h0101);
    bus(1'b1, OFS_STATUS, 32'h2, 4'hF);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF);
    chk("gain clear", rdat[ST_GAIN_E], 1'b0);
    bus(1'b0, 5'h18, 32'h0, 4'hF);
    chk("unmapped", rdat, 32'h0);
  endtask : t_gain

  // main sequence
  initial begin
    num_errors = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    por_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    pull_low = 8'h01;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    @(negedge clock);
    chk("power a", ao_a, CODE_RST);
    chk("power dout", dout_pin, DOUT_RST);
    chk("power drive", dout_drive, 1'b0);
    @(posedge clock);
    t_trig();
    t_code();
    t_dio();
    t_gain();
    finish_test();
  end
endmodule : testbench
